// ===== rtl/tsq_core.v
// trigger sequencer control/status logic with avalon-mm register slave
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`include "tsq_regs.vh"

// Functional notes
// - bit 15 set enables sequencer; cleared stops the executor, returns it to command 0 and drives all lines low.
// - bit 13 set stops sequencer during device idle; clear keeps it running.
// - bit 12 set: trigger command toggles line; clear: one timed pulse.
// - writing one to bit 10 triggers while bit 15 is set; writing zero does nothing.
// - bit 9 enables single-step command execution, for debug tools only.
// - bit 8 set: step, loop and timer limit registers read live counters; clear: written limits.
// - bit 7 set starts continuous command execution; clear stops it.
// - bit 6 set by hardware on watchdog timeout; cleared by any low-byte control write.
// - two-bit wait mode affects only the wait-high and wait-low commands.
// - bits 14, 11 and 5..2 unimplemented and read zero.
module tsq_core
#(
    parameter NLINES  = 4,
    parameter NCMDS   = 16,
    parameter CMD_AW  = 4,
    parameter PW_W    = 4
)
(
    input  wire              clk,
    input  wire              sys_rst,
    input  wire [2:0]        avs_address,
    input  wire              avs_read,
    input  wire              avs_write,
    input  wire [31:0]       avs_writedata,
    input  wire [3:0]        avs_byteenable,
    output reg  [31:0]       avs_readdata,
    output reg               avs_waitrequest,
    input  wire              idle_mode,
    input  wire [NLINES-1:0] wait_inputs,
    input  wire [PW_W-1:0]   pulse_width_field,
    output reg  [NLINES-1:0] trigger_output_line,
    output reg               irq
);

    // ************************************************************
    // states of the command executor (one-hot)
    // ************************************************************
    localparam [3:0] S_IDLE  = 4'b0001;
    localparam [3:0] S_FETCH = 4'b0010;
    localparam [3:0] S_WAIT  = 4'b0100;
    localparam [3:0] S_HOLD  = 4'b1000;

    reg  [15:0]       ctrl_q;
    reg  [15:0]       step_lim_q;
    reg  [15:0]       loop_lim_q;
    reg  [15:0]       timer_lim_q;
    reg  [15:0]       wdt_lim_q;
    reg  [15:0]       step_cnt_q;
    reg  [15:0]       loop_cnt_q;
    reg  [15:0]       timer_q;
    reg  [15:0]       wdt_cnt_q;
    reg  [`TSQ_IRQ_W-1:0] stat_q;
    reg  [`TSQ_IRQ_W-1:0] mask_q;
    reg  [7:0]        cmd_mem [0:NCMDS-1];
    reg  [CMD_AW-1:0] pc_q;
    reg  [CMD_AW-1:0] cmd_wptr_q;
    reg  [3:0]        state_q;
    reg  [7:0]        cmd_q;
    reg  [PW_W-1:0]   pw_cnt_q;
    reg  [NLINES-1:0] pulse_q;
    reg               swt_pend_q;
    reg               step_go_q;
    reg               ack_q;
    reg  [NLINES-1:0] trig_d;

    wire        acc      = (avs_read | avs_write) & ~ack_q;
    wire        wr       = avs_write & ack_q;
    wire        wr_lo    = wr & avs_byteenable[0];
    wire        wr_hi    = wr & avs_byteenable[1];
    wire [15:0] wmask    = {{8{wr_hi}}, {8{wr_lo}}};
    wire        en       = ctrl_q[`TSQ_B_ON];
    // stopped in idle only when the stop-in-idle bit is set
    wire        active   = en & ~(ctrl_q[`TSQ_B_SIDL] & idle_mode);
    wire        ssen     = ctrl_q[`TSQ_B_SSEN];
    // run bit sets continuous mode; single step advances per run write
    wire        go       = active & ctrl_q[`TSQ_B_RUN]
                           & (~ssen | step_go_q);
    wire [3:0]  op       = cmd_q[7:4];
    wire [3:0]  arg      = cmd_q[3:0];
    wire [1:0]  itm      = ctrl_q[`TSQ_F_ITM_HI:`TSQ_F_ITM_LO];
    wire        in_bit   = wait_inputs[arg[CMD_AW-3:0]];
    wire        swt_wr   = wr_hi & avs_writedata[`TSQ_B_SWT] & en;
    wire        wdt_hit  = en & (state_q == S_WAIT)
                           & (wdt_cnt_q == wdt_lim_q)
                           & (wdt_lim_q != `TSQ_ZERO16);
    wire        trig_ev  = active & (state_q == S_HOLD) & (op == `TSQ_OP_TRIG);
    wire [`TSQ_IRQ_W-1:0] ev = {swt_wr, trig_ev, wdt_hit};

    // ************************************************************
    // wait condition: mode matters only for the two wait commands
    // ************************************************************
    reg wait_done;
    always @*
    begin
        wait_done = 1'b1;
        case (op)
            `TSQ_OP_WHI: wait_done = (itm == `TSQ_ITM_CONT) ? in_bit
                                     : (in_bit & timer_q[0]);
            `TSQ_OP_WLO: wait_done = (itm == `TSQ_ITM_CONT) ? ~in_bit
                                     : (~in_bit & timer_q[0]);
            `TSQ_OP_CTRL: wait_done = swt_pend_q;
            `TSQ_OP_DELAY: wait_done = (step_cnt_q >= step_lim_q);
            default: wait_done = 1'b1;
        endcase
    end

    // ************************************************************
    // trigger line next value: toggle or pulse
    // ************************************************************
    integer i;
    always @*
    begin
        trig_d = trigger_output_line;
        if (!en)
            trig_d = {NLINES{1'b0}};
        else if (trig_ev && ctrl_q[`TSQ_B_TOGL])
            trig_d[arg[CMD_AW-3:0]] = ~trigger_output_line[arg[CMD_AW-3:0]];
        else
        begin
            for (i = 0; i < NLINES; i = i + 1)
                if (pulse_q[i] && !ctrl_q[`TSQ_B_TOGL])
                    trig_d[i] = (pw_cnt_q != {PW_W{1'b0}});
        end
    end

    // ************************************************************
    // avalon slave: one wait state, then readdata with ack
    // ************************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end
        else
        begin
            ack_q           <= acc;
            avs_waitrequest <= ~acc;
            if (acc)
            begin
                avs_readdata <= 32'h00000000;
                case (avs_address)
                    `TSQ_ADDR_CTRL: avs_readdata[15:0] <=
                        ctrl_q & `TSQ_CTRL_WMASK
                        | (ctrl_q & (`TSQ_ONE16 << `TSQ_B_WDTO));
                    `TSQ_ADDR_STEP_LIM: avs_readdata[15:0] <=
                        ctrl_q[`TSQ_B_IVIS] ? step_cnt_q : step_lim_q;
                    `TSQ_ADDR_LOOP_LIM: avs_readdata[15:0] <=
                        ctrl_q[`TSQ_B_IVIS] ? loop_cnt_q : loop_lim_q;
                    `TSQ_ADDR_TIMER_LIM: avs_readdata[15:0] <=
                        ctrl_q[`TSQ_B_IVIS] ? timer_q : timer_lim_q;
                    `TSQ_ADDR_IRQ_STAT: avs_readdata[`TSQ_IRQ_W-1:0] <= stat_q;
                    `TSQ_ADDR_IRQ_MASK: avs_readdata[`TSQ_IRQ_W-1:0] <= mask_q;
                    `TSQ_ADDR_WDT_LIM: avs_readdata[15:0] <= wdt_lim_q;
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ************************************************************
    // control/status and limit registers
    // ************************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_q      <= `TSQ_CTRL_RST;
            step_lim_q  <= `TSQ_ZERO16;
            loop_lim_q  <= `TSQ_ZERO16;
            timer_lim_q <= `TSQ_ZERO16;
            wdt_lim_q   <= `TSQ_WDT_RST;
            mask_q      <= {`TSQ_IRQ_W{1'b0}};
        end
        else
        begin
            if (avs_address == `TSQ_ADDR_CTRL && wr)
                ctrl_q <= (ctrl_q & ~(wmask & `TSQ_CTRL_WMASK))
                          | (avs_writedata[15:0] & wmask
                             & `TSQ_CTRL_WMASK);
            if (wdt_hit)
                ctrl_q[`TSQ_B_WDTO] <= 1'b1;
            else if (avs_address == `TSQ_ADDR_CTRL && wr_lo)
                ctrl_q[`TSQ_B_WDTO] <= 1'b0;
            // soft trigger is a strobe, never stored
            ctrl_q[`TSQ_B_SWT] <= 1'b0;
            if (wr && avs_address == `TSQ_ADDR_STEP_LIM)
                step_lim_q <= (step_lim_q & ~wmask)
                              | (avs_writedata[15:0] & wmask);
            if (wr && avs_address == `TSQ_ADDR_LOOP_LIM)
                loop_lim_q <= (loop_lim_q & ~wmask)
                              | (avs_writedata[15:0] & wmask);
            if (wr && avs_address == `TSQ_ADDR_TIMER_LIM)
                timer_lim_q <= (timer_lim_q & ~wmask)
                               | (avs_writedata[15:0] & wmask);
            if (wr && avs_address == `TSQ_ADDR_WDT_LIM)
                wdt_lim_q <= (wdt_lim_q & ~wmask)
                             | (avs_writedata[15:0] & wmask);
            if (wr_lo && avs_address == `TSQ_ADDR_IRQ_MASK)
                mask_q <= avs_writedata[`TSQ_IRQ_W-1:0];
        end
    end

    // ************************************************************
    // interrupt status: set wins over write-one-to-clear
    // ************************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            stat_q <= {`TSQ_IRQ_W{1'b0}};
            irq    <= 1'b0;
        end
        else
        begin
            if (wr_lo && avs_address == `TSQ_ADDR_IRQ_STAT)
                stat_q <= (stat_q & ~avs_writedata[`TSQ_IRQ_W-1:0]) | ev;
            else
                stat_q <= stat_q | ev;
            irq <= |(stat_q & mask_q);
        end
    end

    // ************************************************************
    // command store, loaded through the command port
    // ************************************************************
    always @(posedge clk)
    begin
        if (wr_lo && avs_address == `TSQ_ADDR_CMD)
            cmd_mem[cmd_wptr_q] <= avs_writedata[7:0];
    end

    // ************************************************************
    // command executor
    // ************************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q    <= S_IDLE;
            pc_q       <= {CMD_AW{1'b0}};
            cmd_wptr_q <= {CMD_AW{1'b0}};
            cmd_q      <= 8'h00;
            step_cnt_q <= `TSQ_ZERO16;
            loop_cnt_q <= `TSQ_ZERO16;
            timer_q    <= `TSQ_ZERO16;
            wdt_cnt_q  <= `TSQ_ZERO16;
            pw_cnt_q   <= {PW_W{1'b0}};
            pulse_q    <= {NLINES{1'b0}};
            swt_pend_q <= 1'b0;
            step_go_q  <= 1'b0;
            trigger_output_line <= {NLINES{1'b0}};
        end
        else
        begin
            trigger_output_line <= trig_d;
            if (wr_lo && avs_address == `TSQ_ADDR_CMD)
                cmd_wptr_q <= cmd_wptr_q + 1'b1;
            // software trigger held pending until a control step takes it
            if (swt_wr)
                swt_pend_q <= 1'b1;
            else if (state_q == S_WAIT && op == `TSQ_OP_CTRL && go)
                swt_pend_q <= 1'b0;
            if (wr_lo && avs_address == `TSQ_ADDR_CTRL
                && avs_writedata[`TSQ_B_RUN] && ssen)
                step_go_q <= 1'b1;
            else if (state_q == S_HOLD)
                step_go_q <= 1'b0;
            if (pw_cnt_q != {PW_W{1'b0}})
                pw_cnt_q <= pw_cnt_q - 1'b1;
            else
                pulse_q <= {NLINES{1'b0}};
            timer_q <= (timer_q >= timer_lim_q) ? `TSQ_ZERO16
                       : timer_q + `TSQ_ONE16;
            if (!en)
            begin
                state_q <= S_IDLE;
                pc_q    <= {CMD_AW{1'b0}};
                pulse_q <= {NLINES{1'b0}};
                pw_cnt_q <= {PW_W{1'b0}};
                swt_pend_q <= 1'b0;
            end
            else
            begin
                case (state_q)
                    S_IDLE:
                    begin
                        if (go)
                            state_q <= S_FETCH;
                    end
                    S_FETCH:
                    begin
                        cmd_q      <= cmd_mem[pc_q];
                        step_cnt_q <= `TSQ_ZERO16;
                        wdt_cnt_q  <= `TSQ_ZERO16;
                        state_q    <= S_WAIT;
                    end
                    S_WAIT:
                    begin
                        if (active)
                        begin
                            step_cnt_q <= step_cnt_q + `TSQ_ONE16;
                            wdt_cnt_q  <= wdt_cnt_q + `TSQ_ONE16;
                        end
                        if (wdt_hit)
                            state_q <= S_IDLE;
                        else if (go && wait_done)
                            state_q <= S_HOLD;
                    end
                    S_HOLD:
                    begin
                        if (trig_ev && !ctrl_q[`TSQ_B_TOGL])
                        begin
                            pulse_q[arg[CMD_AW-3:0]] <= 1'b1;
                            pw_cnt_q <= pulse_width_field;
                        end
                        if (op == `TSQ_OP_LOOP
                            && loop_cnt_q < loop_lim_q)
                        begin
                            loop_cnt_q <= loop_cnt_q + `TSQ_ONE16;
                            pc_q <= arg[CMD_AW-1:0];
                        end
                        else
                        begin
                            if (op == `TSQ_OP_LOOP)
                                loop_cnt_q <= `TSQ_ZERO16;
                            pc_q <= pc_q + 1'b1;
                        end
                        state_q <= ctrl_q[`TSQ_B_RUN] ? S_FETCH : S_IDLE;
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

endmodule

// ===== rtl/tsq_regs.vh
// register offsets, field positions and reset values of the trigger sequencer
`ifndef TSQ_REGS_VH
`define TSQ_REGS_VH

// ************************************************************
// word addresses (word index on the avalon bus)
// ************************************************************
`define TSQ_ADDR_CTRL      3'h0
`define TSQ_ADDR_STEP_LIM  3'h1
`define TSQ_ADDR_LOOP_LIM  3'h2
`define TSQ_ADDR_TIMER_LIM 3'h3
`define TSQ_ADDR_IRQ_STAT  3'h4
`define TSQ_ADDR_IRQ_MASK  3'h5
`define TSQ_ADDR_CMD       3'h6
`define TSQ_ADDR_WDT_LIM   3'h7

// ************************************************************
// control/status field positions
// ************************************************************
`define TSQ_B_ON      15
`define TSQ_B_SIDL    13
`define TSQ_B_TOGL    12
`define TSQ_B_SWT     10
`define TSQ_B_SSEN    9
`define TSQ_B_IVIS    8
`define TSQ_B_RUN     7
`define TSQ_B_WDTO    6
`define TSQ_F_ITM_HI  1
`define TSQ_F_ITM_LO  0
`define TSQ_CTRL_WMASK 16'hB783
`define TSQ_CTRL_RST   16'h0000

// ************************************************************
// interrupt status bits
// ************************************************************
`define TSQ_I_WDT     0
`define TSQ_I_TRIG    1
`define TSQ_I_SWT     2
`define TSQ_IRQ_W     3

// ************************************************************
// command word: [7:4] opcode, [3:0] operand
// ************************************************************
`define TSQ_OP_NOP    4'h0
`define TSQ_OP_TRIG   4'h1
`define TSQ_OP_WHI    4'h2
`define TSQ_OP_WLO    4'h3
`define TSQ_OP_CTRL   4'h4
`define TSQ_OP_DELAY  4'h5
`define TSQ_OP_LOOP   4'h6

// ************************************************************
// misc constants
// ************************************************************
`define TSQ_ZERO16    16'h0000
`define TSQ_ONE16     16'h0001
`define TSQ_WDT_RST   16'h0100
`define TSQ_ITM_CONT  2'h0

`endif

// ===== tb/tsq_checker.sv
// port-level checks for the trigger sequencer control block
// ************************************************************
// port checker
// ************************************************************
module tsq_checker
#(
    parameter NLINES = 4,
    parameter PW_W   = 4
)
(
    input wire              clk,
    input wire              sys_rst,
    input wire [2:0]        avs_address,
    input wire              avs_read,
    input wire              avs_write,
    input wire [31:0]       avs_writedata,
    input wire [3:0]        avs_byteenable,
    input wire [31:0]       avs_readdata,
    input wire              avs_waitrequest,
    input wire              idle_mode,
    input wire [NLINES-1:0] wait_inputs,
    input wire [PW_W-1:0]   pulse_width_field,
    input wire [NLINES-1:0] trigger_output_line,
    input wire              irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sh_q;
    logic [15:0] wm;
    logic [2:0]  off_q;
    // shadow of control bits 15, 13, 12, 8, 1 and 0, and cycles spent off
    assign wm = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & 16'hB103;
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            sh_q  <= 16'h0000;
            off_q <= 3'h0;
        end
        else
        begin
            if (avs_write && !avs_waitrequest && avs_address == 3'h0)
                sh_q <= (avs_writedata[15:0] & wm) | (sh_q & ~wm);
            off_q <= sh_q[15] ? 3'h0 : off_q + {2'h0, off_q != 3'h7};
        end
    end

    chk_ack_one_cycle:
    assert property (@(posedge clk) disable iff (sys_rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered one cycle after the take");
    chk_ack_stands:
    assert property (@(posedge clk) disable iff (sys_rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_no_spurious:
    assert property (@(posedge clk) disable iff (sys_rst)
        !avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without a request");
    chk_unimpl_zero:
    assert property (@(posedge clk) disable iff (sys_rst)
        avs_read && !avs_waitrequest && avs_address == 3'h0
        |-> (avs_readdata[15:0] & 16'h4C3C) == 16'h0000)
        else $error("unimplemented control bits read nonzero");
    chk_ctrl_readback:
    assert property (@(posedge clk) disable iff (sys_rst)
        avs_read && !avs_waitrequest && avs_address == 3'h0
        |-> (avs_readdata[15:0] & 16'hB103) == sh_q)
        else $error("control bits read back wrong");
    chk_off_quiet:
    assert property (@(posedge clk) disable iff (sys_rst)
        off_q == 3'h7 |-> trigger_output_line == '0)
        else $error("trigger line active while module off");
    chk_reset_quiet:
    assert property (@(posedge clk)
        sys_rst |=> avs_waitrequest && !irq && trigger_output_line == '0)
        else $error("outputs not at reset level");
    chk_pulse_ends:
    assert property (@(posedge clk) disable iff (sys_rst)
        sh_q[15] && !sh_q[12] && $rose(trigger_output_line[0])
        |-> ##[1:24] !trigger_output_line[0])
        else $error("pulse on line 0 did not end");
endmodule

// ===== tb/tsq_periph.sv
// far-side peripheral: registers the levels seen by the wait commands
// ************************************************************
// peripheral model
// ************************************************************
module tsq_periph
#(
    parameter NLINES = 4
)
(
    input  wire logic              clk,
    input  wire logic [NLINES-1:0] level,
    output logic      [NLINES-1:0] wait_inputs
);
    timeunit 1ns;
    timeprecision 1ps;
    // status flags change only just after a clock edge
    always @(posedge clk)
    begin
        wait_inputs <= level;
    end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the trigger sequencer control block
`include "tsq_regs.vh"
// ************************************************************
// bench top
// ************************************************************
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam NLINES = 4;
    localparam PW_W   = 4;
    logic              clk;
    logic              sys_rst;
    logic [2:0]        avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              idle_mode;
    logic [NLINES-1:0] wait_inputs;
    logic [NLINES-1:0] level;
    logic [PW_W-1:0]   pw;
    logic [NLINES-1:0] trigger_output_line;
    logic              irq;
    logic [15:0]       v;
    int                n;
    int                bad_count;
    int                checked;
    logic [15:0]       exp_q[$];
    logic [15:0]       msk_q[$];

    tsq_core #(.NLINES(NLINES), .PW_W(PW_W)) tsq_core_inst (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .idle_mode(idle_mode), .wait_inputs(wait_inputs),
        .pulse_width_field(pw),
        .trigger_output_line(trigger_output_line), .irq(irq));
    tsq_periph #(.NLINES(NLINES)) tsq_periph_inst (
        .clk(clk), .level(level), .wait_inputs(wait_inputs));

    // free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
        checked++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask

    task automatic timeout(input string nm);
        $display("[FAIL] %s expected answer seen timeout", nm);
        bad_count++;
        print_verdict();
    endtask

    // one avalon access; a read notes its masked expectation first
    task automatic bus(input logic w, input logic [2:0] a,
                       input logic [15:0] d, input logic [15:0] m);
        int k;
        k = 0;
        if (!w)
        begin
            exp_q.push_back(d & m);
            msk_q.push_back(m);
        end
        @(posedge clk);
        avs_write     <= w;
        avs_read      <= !w;
        avs_address   <= a;
        avs_writedata <= {16'h0000, d};
        do
        begin
            @(posedge clk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 40);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (k >= 40)
            timeout("bus");
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        bus(1'b1, a, d, 16'h0000);
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] e,
                      input logic [15:0] m);
        bus(1'b0, a, e, m);
    endtask

    // bounded wait for line 0 (sel 0) or irq (sel 1) to reach v
    task automatic wfor(input logic v, input logic sel, input int lim);
        int k;
        k = 0;
        while ((sel ? irq : trigger_output_line[0]) !== v && k < lim)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= lim)
            timeout(sel ? "irq" : "line0");
        checked++;
    endtask

    // all trigger lines (sel 0) or irq (sel 1) stay low for cyc cycles
    task automatic quiet(input logic sel, input int cyc);
        logic seen;
        seen = 1'b0;
        repeat (cyc)
        begin
            @(posedge clk);
            if ((sel ? irq : |trigger_output_line) !== 1'b0) seen = 1'b1;
        end
        chk(sel ? "irq quiet" : "lines quiet", 16'h0000, {15'h0000, seen});
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    // compares each read answer with the oldest note in the queue
    always @(posedge clk)
    begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            chk("readdata", exp_q.pop_front(),
                avs_readdata[15:0] & msk_q.pop_front());
    end

    // main sequence
    initial
    begin
        {avs_read, avs_write, idle_mode} = 3'h0;
        avs_address    = 3'h0;
        avs_writedata  = 32'h00000000;
        avs_byteenable = 4'hF;
        level          = 4'h0;
        pw             = 4'h1;
        bad_count      = 0;
        checked        = 0;
        v = 16'($urandom(32'hBDDC));
        do_reset();
        rd(`TSQ_ADDR_CTRL, 16'h0000, 16'hFFFF);
        rd(`TSQ_ADDR_WDT_LIM, 16'h0100, 16'hFFFF);
        wr(`TSQ_ADDR_CTRL, 16'h4C3C);
        rd(`TSQ_ADDR_CTRL, 16'h0000, 16'hFFFF);
        rd(`TSQ_ADDR_IRQ_STAT, 16'h0000, 16'h0004);
        $display("test reset and reserved bits done");
        for (int a = 1; a < 4; a++)
        begin
            v = 16'($urandom);
            wr(a[2:0], v);
            rd(a[2:0], v, 16'hFFFF);
        end
        wr(`TSQ_ADDR_CTRL, 16'h0103);
        rd(`TSQ_ADDR_CTRL, 16'h0103, 16'hFFFF);
        rd(`TSQ_ADDR_STEP_LIM, 16'h0000, 16'hFFFF);
        $display("test limits and visibility done");
        wr(`TSQ_ADDR_CMD, 16'h0010);
        wr(`TSQ_ADDR_CTRL, 16'h1480);
        quiet(1'b0, 40);
        wr(`TSQ_ADDR_CTRL, 16'h9080);
        wfor(1'b1, 1'b0, 200);
        wr(`TSQ_ADDR_CTRL, 16'h0000);
        wfor(1'b0, 1'b0, 20);
        quiet(1'b0, 20);
        $display("test toggle and run done");
        do_reset();
        pw <= 4'(1 + $urandom % 8);
        wr(`TSQ_ADDR_CMD, 16'h0020);
        wr(`TSQ_ADDR_CMD, 16'h0010);
        wr(`TSQ_ADDR_CTRL, 16'h8080);
        quiet(1'b0, 40);
        level <= 4'h1;
        wfor(1'b1, 1'b0, 200);
        n = 0;
        while (trigger_output_line[0] === 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        chk("pulse width", {12'h000, pw}, n[15:0]);
        wr(`TSQ_ADDR_CTRL, 16'h0000);
        $display("test pulse and wait done");
        wr(`TSQ_ADDR_IRQ_MASK, 16'h0004);
        wr(`TSQ_ADDR_CTRL, 16'h8000);
        quiet(1'b1, 20);
        wr(`TSQ_ADDR_CTRL, 16'h8400);
        wfor(1'b1, 1'b1, 50);
        rd(`TSQ_ADDR_IRQ_STAT, 16'h0004, 16'h0004);
        rd(`TSQ_ADDR_CTRL, 16'h8000, 16'hFFFF);
        wr(`TSQ_ADDR_IRQ_STAT, 16'h0004);
        wfor(1'b0, 1'b1, 20);
        wr(`TSQ_ADDR_IRQ_MASK, 16'h0000);
        wr(`TSQ_ADDR_CTRL, 16'h8400);
        rd(`TSQ_ADDR_IRQ_STAT, 16'h0004, 16'h0004);
        quiet(1'b1, 10);
        $display("test soft trigger and interrupt done");
        do_reset();
        level <= 4'h0;
        idle_mode <= 1'b1;
        wr(`TSQ_ADDR_CMD, 16'h0010);
        wr(`TSQ_ADDR_CTRL, 16'hB080);
        quiet(1'b0, 40);
        idle_mode <= 1'b0;
        wfor(1'b1, 1'b0, 200);
        $display("test halt in idle done");
        do_reset();
        wr(`TSQ_ADDR_CMD, 16'h0010);
        wr(`TSQ_ADDR_CMD, 16'h0010);
        wr(`TSQ_ADDR_CTRL, 16'h9280);
        quiet(1'b0, 20);
        wr(`TSQ_ADDR_CTRL, 16'h9280);
        wfor(1'b1, 1'b0, 20);
        repeat (20) @(posedge clk);
        chk("step hold", 16'h0001,
            {15'h0000, trigger_output_line[0]});
        wr(`TSQ_ADDR_CTRL, 16'h9280);
        wfor(1'b0, 1'b0, 20);
        do_reset();
        wr(`TSQ_ADDR_CMD, 16'h0020);
        wr(`TSQ_ADDR_WDT_LIM, 16'h0010);
        wr(`TSQ_ADDR_IRQ_MASK, 16'h0001);
        wr(`TSQ_ADDR_CTRL, 16'h8080);
        wfor(1'b1, 1'b1, 100);
        rd(`TSQ_ADDR_CTRL, 16'h0040, 16'h0040);
        $display("test single step and watchdog done");
        print_verdict();
    end
endmodule

bind tsq_core tsq_checker #(.NLINES(NLINES), .PW_W(PW_W)) tsq_checker_inst (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .idle_mode(idle_mode), .wait_inputs(wait_inputs),
    .pulse_width_field(pulse_width_field),
    .trigger_output_line(trigger_output_line), .irq(irq));
